// ===== shared/vra_pkg.sv
// Constants and state type for the vendor register access block
package vra_pkg;
  // Request types and codes
  localparam logic [7:0] T_WR_GEN = 8'h41;
  localparam logic [7:0] T_RD_GEN = 8'hc1;
  localparam logic [7:0] T_RD_DEV = 8'hc0;
  localparam logic [7:0] T_WR_DEV = 8'h40;
  localparam logic [7:0] C_REG = 8'h00;
  localparam logic [7:0] C_ID = 8'hff;
  // Channel selectors
  localparam logic [7:0] CH_A = 8'h00;
  localparam logic [7:0] CH_B = 8'h02;
  // Dedicated indexes
  localparam logic [15:0] IX_REV = 16'h0260;
  localparam logic [15:0] IX_STAT = 16'h0262;
  // Register offsets
  localparam logic [7:0] A_EN = 8'h00;
  localparam logic [7:0] A_HS = 8'h06;
  localparam logic [7:0] A_XON = 8'h07;
  localparam logic [7:0] A_XOFF = 8'h08;
  localparam logic [7:0] A_ERR = 8'h09;
  localparam logic [7:0] A_BRK = 8'h0a;
  localparam logic [7:0] A_DLY = 8'h0b;
  localparam logic [7:0] A_PFN = 8'h0c;
  localparam logic [7:0] A_DIR = 8'h0d;
  localparam logic [7:0] A_PSET = 8'h0e;
  localparam logic [7:0] A_PCLR = 8'h0f;
  localparam logic [7:0] A_PLVL = 8'h10;
  localparam logic [7:0] A_IMSK = 8'h11;
  localparam logic [7:0] A_CINT = 8'h12;
  // Writable bit masks
  localparam logic [15:0] M_EN = 16'h0003;
  localparam logic [15:0] M_HS = 16'h000f;
  localparam logic [15:0] M_BYTE = 16'h00ff;
  localparam logic [15:0] M_DLY = 16'h000f;
  localparam logic [15:0] M_PIN = 16'h03ff;
  localparam logic [15:0] M_IMSK = 16'h07ff;
  localparam logic [15:0] M_CINT = 16'h0003;
  localparam logic [15:0] M_STAT = 16'h3f3f;
  // Reply lengths
  localparam logic [2:0] L_NONE = 3'h0;
  localparam logic [2:0] L_WORD = 3'h2;
  localparam logic [2:0] L_ID = 3'h6;
  // Arbitrary identity and revision values
  localparam logic [15:0] ID_VEND = 16'h1234;
  localparam logic [15:0] ID_PROD = 16'h5678;
  localparam logic [15:0] ID_REL = 16'h0100;
  localparam logic [15:0] REV_ID = 16'h0001;

  typedef struct packed {
    logic [1:0][15:0] en;
    logic [1:0][15:0] hs;
    logic [1:0][15:0] xon;
    logic [1:0][15:0] xoff;
    logic [1:0][15:0] err;
    logic [1:0][15:0] brk;
    logic [1:0][15:0] dly;
    logic [1:0][15:0] pfn;
    logic [1:0][15:0] dir;
    logic [1:0][15:0] pout;
    logic [1:0][15:0] imsk;
    logic [1:0][15:0] cint;
    logic [15:0] stat;
    logic rvalid;
    logic stall;
    logic [2:0] rlen;
    logic [47:0] rdata;
  } vra_state_t;
endpackage : vra_pkg

// ===== rtl/vra_top.sv
// Vendor control request decoder with dual channel register set
`timescale 1ns/1ns
module vra_top (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic setup_valid_in,
  input wire logic [7:0] req_type_in,
  input wire logic [7:0] req_code_in,
  input wire logic [15:0] req_value_in,
  input wire logic [15:0] req_index_in,
  input wire logic [9:0] line_event_in,
  input wire logic [23:0] pin_level_in,
  output logic reply_valid_out,
  output logic reply_stall_out,
  output logic [2:0] reply_len_out,
  output logic [47:0] reply_data_out,
  output logic [3:0] serial_enable_out,
  output logic [7:0] handshake_out,
  output logic [19:0] pin_function_out,
  output logic [19:0] pin_direction_out,
  output logic [19:0] pin_output_out,
  output logic [3:0] custom_int_out,
  output logic [15:0] bus_status_out
);
  vra_pkg::vra_state_t s_reg;
  vra_pkg::vra_state_t s_next;
  logic ch;
  logic ok;
  logic hit;
  logic wr;
  logic [7:0] a;
  logic [15:0] v;
  logic [15:0] rd;

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.stall = 1'b0;
    s_next.rlen = vra_pkg::L_NONE;
    s_next.rdata = 48'h0;
    ch = (req_index_in[15:8] == vra_pkg::CH_B);
    ok = ch || (req_index_in[15:8] == vra_pkg::CH_A);
    a = req_index_in[7:0];
    v = req_value_in;
    hit = 1'b1;
    wr = 1'b1;
    rd = 16'h0;
    // Sticky line error flags
    for (int c = 0; c < 2; c++) begin
      s_next.err[c] = s_reg.err[c] | {8'h0, line_event_in[c*5 +: 5], 3'h0};
    end
    // Generic read mux
    if (a == vra_pkg::A_EN) begin
      rd = s_reg.en[ch];
    end else if (a == vra_pkg::A_HS) begin
      rd = s_reg.hs[ch];
    end else if (a == vra_pkg::A_XON) begin
      rd = s_reg.xon[ch];
    end else if (a == vra_pkg::A_XOFF) begin
      rd = s_reg.xoff[ch];
    end else if (a == vra_pkg::A_ERR) begin
      rd = s_reg.err[ch];
    end else if (a == vra_pkg::A_BRK) begin
      rd = s_reg.brk[ch];
    end else if (a == vra_pkg::A_DLY) begin
      rd = s_reg.dly[ch];
    end else if (a == vra_pkg::A_PFN) begin
      rd = s_reg.pfn[ch];
    end else if (a == vra_pkg::A_DIR) begin
      rd = s_reg.dir[ch];
    end else if (a == vra_pkg::A_PSET || a == vra_pkg::A_PCLR) begin
      rd = 16'h0;
    end else if (a == vra_pkg::A_PLVL) begin
      rd = {4'h0, ch ? pin_level_in[23:12] : pin_level_in[11:0]};
    end else if (a == vra_pkg::A_IMSK) begin
      rd = s_reg.imsk[ch];
    end else if (a == vra_pkg::A_CINT) begin
      rd = s_reg.cint[ch];
    end else begin
      hit = 1'b0;
    end
    if (setup_valid_in) begin
      if (req_type_in == vra_pkg::T_WR_GEN && req_code_in == vra_pkg::C_REG && ok) begin
        // Generic write, masked to defined bits
        if (a == vra_pkg::A_EN) begin
          s_next.en[ch] = v & vra_pkg::M_EN;
        end else if (a == vra_pkg::A_HS) begin
          s_next.hs[ch] = v & vra_pkg::M_HS;
        end else if (a == vra_pkg::A_XON) begin
          s_next.xon[ch] = v & vra_pkg::M_BYTE;
        end else if (a == vra_pkg::A_XOFF) begin
          s_next.xoff[ch] = v & vra_pkg::M_BYTE;
        end else if (a == vra_pkg::A_BRK) begin
          s_next.brk[ch] = v;
        end else if (a == vra_pkg::A_DLY) begin
          s_next.dly[ch] = v & vra_pkg::M_DLY;
        end else if (a == vra_pkg::A_PFN) begin
          s_next.pfn[ch] = v & vra_pkg::M_PIN;
        end else if (a == vra_pkg::A_DIR) begin
          s_next.dir[ch] = v & vra_pkg::M_PIN;
        end else if (a == vra_pkg::A_PSET) begin
          s_next.pout[ch] = s_reg.pout[ch] | (v & vra_pkg::M_PIN);
        end else if (a == vra_pkg::A_PCLR) begin
          s_next.pout[ch] = s_reg.pout[ch] & ~(v & vra_pkg::M_PIN);
        end else if (a == vra_pkg::A_IMSK) begin
          s_next.imsk[ch] = v & vra_pkg::M_IMSK;
        end else if (a == vra_pkg::A_CINT) begin
          s_next.cint[ch] = v & vra_pkg::M_CINT;
        end else begin
          wr = 1'b0;
        end
        s_next.rvalid = wr;
        s_next.stall = !wr;
      end else if (req_type_in == vra_pkg::T_RD_GEN && req_code_in == vra_pkg::C_REG
                   && ok && v == 16'h0) begin
        s_next.rvalid = hit;
        s_next.stall = !hit;
        s_next.rlen = hit ? vra_pkg::L_WORD : vra_pkg::L_NONE;
        s_next.rdata = {32'h0, rd};
        if (hit && a == vra_pkg::A_ERR) begin
          // Read clears, a new event still lands
          s_next.err[ch] = {8'h0, ch ? line_event_in[9:5] : line_event_in[4:0], 3'h0};
        end
      end else if (req_type_in == vra_pkg::T_RD_DEV && req_code_in == vra_pkg::C_REG
                   && v == 16'h0 && req_index_in == vra_pkg::IX_REV) begin
        s_next.rvalid = 1'b1;
        s_next.rlen = vra_pkg::L_WORD;
        s_next.rdata = {32'h0, vra_pkg::REV_ID};
      end else if (req_type_in == vra_pkg::T_WR_DEV && req_code_in == vra_pkg::C_REG
                   && req_index_in == vra_pkg::IX_STAT) begin
        s_next.stat = v & vra_pkg::M_STAT;
        s_next.rvalid = 1'b1;
      end else if (req_type_in == vra_pkg::T_RD_DEV && req_code_in == vra_pkg::C_REG
                   && v == 16'h0 && req_index_in == vra_pkg::IX_STAT) begin
        s_next.rvalid = 1'b1;
        s_next.rlen = vra_pkg::L_WORD;
        s_next.rdata = {32'h0, s_reg.stat};
      end else if (req_type_in == vra_pkg::T_RD_DEV && req_code_in == vra_pkg::C_ID
                   && v == 16'h0 && req_index_in == 16'h0) begin
        s_next.rvalid = 1'b1;
        s_next.rlen = vra_pkg::L_ID;
        s_next.rdata = {vra_pkg::ID_REL, vra_pkg::ID_PROD, vra_pkg::ID_VEND};
      end else begin
        s_next.stall = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reply_valid_out = s_reg.rvalid;
  assign reply_stall_out = s_reg.stall;
  assign reply_len_out = s_reg.rlen;
  assign reply_data_out = s_reg.rdata;
  assign serial_enable_out = {s_reg.en[1][1:0], s_reg.en[0][1:0]};
  assign handshake_out = {s_reg.hs[1][3:0], s_reg.hs[0][3:0]};
  assign pin_function_out = {s_reg.pfn[1][9:0], s_reg.pfn[0][9:0]};
  assign pin_direction_out = {s_reg.dir[1][9:0], s_reg.dir[0][9:0]};
  assign pin_output_out = {s_reg.pout[1][9:0], s_reg.pout[0][9:0]};
  assign custom_int_out = {s_reg.cint[1][1:0], s_reg.cint[0][1:0]};
  assign bus_status_out = s_reg.stat;

  // Checks
  logic h_gw;
  logic h_gr;
  logic h_dr;
  logic h_sw;
  logic h_er;
  assign h_gw = setup_valid_in && req_type_in == vra_pkg::T_WR_GEN && req_code_in == 8'h00;
  assign h_gr = setup_valid_in && req_type_in == vra_pkg::T_RD_GEN && req_code_in == 8'h00;
  assign h_dr = setup_valid_in && req_type_in == vra_pkg::T_RD_DEV && req_code_in == 8'h00
                && req_value_in == 16'h0;
  assign h_sw = setup_valid_in && req_type_in == vra_pkg::T_WR_DEV && req_code_in == 8'h00
                && req_index_in == vra_pkg::IX_STAT;
  assign h_er = h_gr && req_value_in == 16'h0 && req_index_in == {vra_pkg::CH_A, vra_pkg::A_ERR};

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  property p_gen_wr;
    h_gw && req_index_in == {vra_pkg::CH_A, vra_pkg::A_EN}
      |=> reply_valid_out && serial_enable_out[1:0] == $past(req_value_in[1:0]);
  endproperty
  a_gen_wr: assert property (p_gen_wr) else $error("generic write lost");
  property p_gen_rd;
    h_gr && req_value_in == 16'h0 && req_index_in == {vra_pkg::CH_A, vra_pkg::A_HS}
      |=> reply_valid_out && reply_len_out == 3'h2 && reply_data_out[15:0] == $past(s_reg.hs[0]);
  endproperty
  a_gen_rd: assert property (p_gen_rd) else $error("generic read wrong");
  property p_chan_b;
    h_gw && req_index_in == {vra_pkg::CH_B, vra_pkg::A_EN}
      |=> serial_enable_out[3:2] == $past(req_value_in[1:0]) && $stable(serial_enable_out[1:0]);
  endproperty
  a_chan_b: assert property (p_chan_b) else $error("channel select wrong");
  property p_rev;
    h_dr && req_index_in == vra_pkg::IX_REV
      |=> reply_valid_out && reply_len_out == 3'h2 && reply_data_out[15:0] == vra_pkg::REV_ID;
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  property p_stat_wr;
    h_sw |=> bus_status_out == ($past(req_value_in) & vra_pkg::M_STAT)
      ##1 ($stable(bus_status_out) || $past(h_sw));
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status write lost");
  property p_stat_rd;
    h_dr && req_index_in == vra_pkg::IX_STAT
      |=> reply_len_out == 3'h2 && reply_data_out[15:0] == bus_status_out;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");
  property p_id;
    setup_valid_in && req_type_in == vra_pkg::T_RD_DEV && req_code_in == vra_pkg::C_ID
      && req_value_in == 16'h0 && req_index_in == 16'h0
      |=> reply_len_out == 3'h6 && reply_data_out[15:0] == vra_pkg::ID_VEND;
  endproperty
  a_id: assert property (p_id) else $error("identity read wrong");
  property p_no_gen_rev;
    h_gr && req_index_in[7:0] == vra_pkg::IX_REV[7:0] |=> reply_stall_out && !reply_valid_out;
  endproperty
  a_no_gen_rev: assert property (p_no_gen_rev) else $error("revision via generic");
  property p_width;
    reply_valid_out && reply_len_out == 3'h2 |-> reply_data_out[47:16] == 32'h0;
  endproperty
  a_width: assert property (p_width) else $error("word reply too wide");
  property p_err;
    line_event_in[4] |=> s_reg.err[0][7] ##1 (s_reg.err[0][7] || $past(h_er));
  endproperty
  a_err: assert property (p_err) else $error("break status not sticky");
  property p_hs;
    h_gw && req_index_in == {vra_pkg::CH_A, vra_pkg::A_HS}
      |=> handshake_out[3:0] == $past(req_value_in[3:0]) && s_reg.hs[0][15:4] == 12'h0;
  endproperty
  a_hs: assert property (p_hs) else $error("handshake layout wrong");
  property p_pfn;
    h_gw && req_index_in == {vra_pkg::CH_A, vra_pkg::A_PFN}
      |=> pin_function_out[9:0] == $past(req_value_in[9:0]);
  endproperty
  a_pfn: assert property (p_pfn) else $error("pin function wrong");
  property p_cint;
    h_gw && req_index_in == {vra_pkg::CH_B, vra_pkg::A_CINT}
      |=> custom_int_out[3:2] == $past(req_value_in[1:0]) && s_reg.cint[1][15:2] == 14'h0;
  endproperty
  a_cint: assert property (p_cint) else $error("custom interrupt wrong");
  property p_en_res;
    s_reg.en[0][15:2] == 14'h0 && s_reg.en[1][15:2] == 14'h0;
  endproperty
  a_en_res: assert property (p_en_res) else $error("enable reserved set");
  property p_bad;
    setup_valid_in && req_type_in != vra_pkg::T_WR_GEN && req_type_in != vra_pkg::T_RD_GEN
      && req_type_in != vra_pkg::T_RD_DEV && req_type_in != vra_pkg::T_WR_DEV
      |=> reply_stall_out && $stable(serial_enable_out) && $stable(bus_status_out);
  endproperty
  a_bad: assert property (p_bad) else $error("unknown request not stalled");
  property p_pset;
    h_gw && req_index_in == {vra_pkg::CH_A, vra_pkg::A_PSET}
      |=> pin_output_out[9:0] == ($past(pin_output_out[9:0]) | $past(req_value_in[9:0]));
  endproperty
  a_pset: assert property (p_pset) else $error("pin set wrong");
  property p_pclr;
    h_gw && req_index_in == {vra_pkg::CH_A, vra_pkg::A_PCLR}
      |=> pin_output_out[9:0] == ($past(pin_output_out[9:0]) & ~$past(req_value_in[9:0]));
  endproperty
  a_pclr: assert property (p_pclr) else $error("pin clear wrong");
  property p_dir;
    h_gw && req_index_in == {vra_pkg::CH_B, vra_pkg::A_DIR}
      |=> pin_direction_out[19:10] == $past(req_value_in[9:0])
      && $stable(pin_direction_out[9:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_err_clr;
    h_er |=> s_reg.err[0] == {8'h0, $past(line_event_in[4:0]), 3'h0};
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error clear wrong");
  property p_err_ro;
    h_gw && req_index_in == {vra_pkg::CH_A, vra_pkg::A_ERR}
      |=> reply_stall_out && !reply_valid_out;
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("error register written");
  property p_one_reply;
    !(reply_valid_out && reply_stall_out);
  endproperty
  a_one_reply: assert property (p_one_reply) else $error("valid and stall together");
  property p_quiet;
    !setup_valid_in |=> !reply_valid_out && !reply_stall_out && reply_len_out == 3'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reply without request");

  c_id: cover property (reply_valid_out && reply_len_out == 3'h6);
  c_chan_b: cover property (h_gw && req_index_in[15:8] == vra_pkg::CH_B ##1 reply_valid_out);
  c_stall: cover property (reply_stall_out);
  c_err_rd: cover property (s_reg.err[0] != 16'h0 ##1 h_gr);
  c_pins: cover property (h_gw && req_index_in[7:0] == vra_pkg::A_PCLR ##1 reply_valid_out);
endmodule : vra_top

// ===== verif/vra_host_model.sv
// Host driver model issuing vendor control transfers
`timescale 1ns/1ns
module vra_host_model (
  input wire logic mclk_in,
  input wire logic reply_valid_in,
  input wire logic reply_stall_in,
  input wire logic [2:0] reply_len_in,
  input wire logic [47:0] reply_data_in,
  output logic setup_valid_out,
  output logic [7:0] req_type_out,
  output logic [7:0] req_code_out,
  output logic [15:0] req_value_out,
  output logic [15:0] req_index_out
);
  initial begin
    setup_valid_out = 1'b0;
    req_type_out = 8'h00;
    req_code_out = 8'h00;
    req_value_out = 16'h0000;
    req_index_out = 16'h0000;
  end
  // One setup pulse, answer sampled 1 ns after the edge that takes it
  task automatic xfer(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
                      input logic [15:0] ix, output logic [4:0] ans, output logic [47:0] d);
    @(posedge mclk_in);
    setup_valid_out <= 1'b1;
    req_type_out <= t;
    req_code_out <= c;
    req_value_out <= v;
    req_index_out <= ix;
    @(posedge mclk_in);
    setup_valid_out <= 1'b0;
    // Released fields wander so stale values never look valid
    req_type_out <= ~t;
    req_code_out <= ~c;
    req_value_out <= ~v;
    req_index_out <= ~ix;
    #1;
    ans = {reply_valid_in, reply_stall_in, reply_len_in};
    d = reply_data_in;
  endtask : xfer
endmodule : vra_host_model

// ===== verif/tb_vra_top.sv
// Self-checking testbench for the vendor register access block
`timescale 1ns/1ns
module tb_vra_top;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [9:0] line_event_in = 10'h000;
  logic [23:0] pin_level_in = 24'h000000;
  logic sv, rv, rs;
  logic [7:0] rt, rc, hs_o;
  logic [15:0] vl, ix, bs_o;
  logic [2:0] rl;
  logic [47:0] rd_d;
  logic [3:0] se_o, ci_o;
  logic [19:0] pf_o, pd_o, po_o;
  int num_errors = 0;
  int n_tests = 0;
  localparam logic [4:0] OK_N = {2'b10, vra_pkg::L_NONE};
  localparam logic [4:0] OK_W = {2'b10, vra_pkg::L_WORD};
  localparam logic [4:0] STL = {2'b01, vra_pkg::L_NONE};

  always #10 mclk_in = ~mclk_in;

  vra_host_model host (.mclk_in(mclk_in), .reply_valid_in(rv), .reply_stall_in(rs),
    .reply_len_in(rl), .reply_data_in(rd_d), .setup_valid_out(sv), .req_type_out(rt),
    .req_code_out(rc), .req_value_out(vl), .req_index_out(ix));
  vra_top dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .setup_valid_in(sv),
    .req_type_in(rt), .req_code_in(rc), .req_value_in(vl), .req_index_in(ix),
    .line_event_in(line_event_in), .pin_level_in(pin_level_in), .reply_valid_out(rv),
    .reply_stall_out(rs), .reply_len_out(rl), .reply_data_out(rd_d),
    .serial_enable_out(se_o), .handshake_out(hs_o), .pin_function_out(pf_o),
    .pin_direction_out(pd_o), .pin_output_out(po_o), .custom_int_out(ci_o),
    .bus_status_out(bs_o));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Request and compare answer; data only judged on accepted requests
  task automatic acc(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
                     input logic [15:0] x, input logic [4:0] ea, input logic [47:0] ed);
    logic [4:0] a;
    logic [47:0] d;
    host.xfer(t, c, v, x, a, d);
    chk({a, (ea[4] ? d : 48'h0)}, {ea, ed}, "reply");
  endtask : acc

  task automatic wr(input logic [7:0] ch, input logic [7:0] ad, input logic [15:0] v);
    acc(vra_pkg::T_WR_GEN, vra_pkg::C_REG, v, {ch, ad}, OK_N, 48'h0);
  endtask : wr

  task automatic rd(input logic [7:0] ch, input logic [7:0] ad, input logic [15:0] e);
    acc(vra_pkg::T_RD_GEN, vra_pkg::C_REG, 16'h0000, {ch, ad}, OK_W, {32'h0, e});
  endtask : rd

  task automatic t_reset;
    #1;
    chk({se_o, hs_o, pf_o, ci_o, bs_o, rv, rs}, 64'h0, "reset outputs");
    chk({pd_o, po_o, rl}, 64'h0, "reset pins");
    chk(rd_d, 64'h0, "reset reply");
    $display("test reset done");
  endtask : t_reset

  task automatic t_config;
    logic [15:0] hs[2] = '{16'h000b, 16'h0005};
    logic [15:0] pf[2] = '{16'h03a5, 16'h015a};
    logic [15:0] ci[2] = '{16'h0001, 16'h0002};
    logic [15:0] en[2] = '{16'h0003, 16'h0001};
    logic [7:0] ch;
    for (int i = 0; i < 2; i++) begin
      ch = (i == 0) ? vra_pkg::CH_A : vra_pkg::CH_B;
      wr(ch, vra_pkg::A_EN, 16'h0000);
      wr(ch, vra_pkg::A_HS, hs[i]);
      wr(ch, vra_pkg::A_PFN, pf[i]);
      wr(ch, vra_pkg::A_CINT, ci[i]);
      wr(ch, vra_pkg::A_XON, 16'h0011);
      wr(ch, vra_pkg::A_EN, en[i]);
      rd(ch, vra_pkg::A_HS, hs[i]);
      rd(ch, vra_pkg::A_PFN, pf[i]);
      rd(ch, vra_pkg::A_CINT, ci[i]);
      rd(ch, vra_pkg::A_EN, en[i]);
      rd(ch, vra_pkg::A_XON, 16'h0011);
    end
    chk({se_o, hs_o, ci_o}, {4'h7, 8'h5b, 4'h9}, "config outputs");
    chk(pf_o, 20'h56ba5, "pin function");
    $display("test config done");
  endtask : t_config

  task automatic t_dedicated;
    acc(vra_pkg::T_RD_DEV, vra_pkg::C_REG, 16'h0, vra_pkg::IX_REV, OK_W,
        {32'h0, vra_pkg::REV_ID});
    acc(vra_pkg::T_WR_DEV, vra_pkg::C_REG, 16'h3f3f, vra_pkg::IX_STAT, OK_N, 48'h0);
    chk(bs_o, 16'h3f3f, "bus status");
    acc(vra_pkg::T_RD_DEV, vra_pkg::C_REG, 16'h0, vra_pkg::IX_STAT, OK_W, 48'h3f3f);
    acc(vra_pkg::T_RD_DEV, vra_pkg::C_ID, 16'h0, 16'h0, {2'b10, vra_pkg::L_ID},
        {vra_pkg::ID_REL, vra_pkg::ID_PROD, vra_pkg::ID_VEND});
    acc(vra_pkg::T_RD_GEN, vra_pkg::C_REG, 16'h0, 16'h0060, STL, 48'h0);
    acc(vra_pkg::T_WR_GEN, vra_pkg::C_REG, 16'h0001, 16'h0062, STL, 48'h0);
    $display("test dedicated done");
  endtask : t_dedicated

  task automatic t_errors;
    @(posedge mclk_in);
    line_event_in <= 10'h010;
    pin_level_in <= 24'habc123;
    @(posedge mclk_in);
    line_event_in <= 10'h021;
    @(posedge mclk_in);
    line_event_in <= 10'h000;
    rd(vra_pkg::CH_A, vra_pkg::A_ERR, 16'h0088);
    rd(vra_pkg::CH_A, vra_pkg::A_ERR, 16'h0000);
    rd(vra_pkg::CH_B, vra_pkg::A_ERR, 16'h0008);
    rd(vra_pkg::CH_A, vra_pkg::A_PLVL, 16'h0123);
    rd(vra_pkg::CH_B, vra_pkg::A_PLVL, 16'h0abc);
    $display("test errors done");
  endtask : t_errors

  task automatic t_stall;
    acc(vra_pkg::T_WR_GEN, 8'h05, 16'h0000, 16'h0000, STL, 48'h0);
    acc(8'h42, vra_pkg::C_REG, 16'h0000, 16'h0000, STL, 48'h0);
    acc(vra_pkg::T_WR_GEN, vra_pkg::C_REG, 16'h0000, 16'h0100, STL, 48'h0);
    acc(vra_pkg::T_RD_GEN, vra_pkg::C_REG, 16'h0001, 16'h0006, STL, 48'h0);
    acc(vra_pkg::T_WR_GEN, vra_pkg::C_REG, 16'h0000, 16'h0009, STL, 48'h0);
    acc(vra_pkg::T_RD_GEN, vra_pkg::C_REG, 16'h0000, 16'h0003, STL, 48'h0);
    chk({se_o, hs_o}, {4'h7, 8'h5b}, "unchanged after stalls");
    $display("test stall done");
  endtask : t_stall

  task automatic t_pins;
    wr(vra_pkg::CH_A, vra_pkg::A_EN, 16'h0000);
    wr(vra_pkg::CH_B, vra_pkg::A_EN, 16'h0000);
    wr(vra_pkg::CH_A, vra_pkg::A_DIR, 16'h0155);
    wr(vra_pkg::CH_B, vra_pkg::A_DIR, 16'h02aa);
    wr(vra_pkg::CH_B, vra_pkg::A_BRK, 16'hbeef);
    wr(vra_pkg::CH_B, vra_pkg::A_DLY, 16'h0007);
    wr(vra_pkg::CH_B, vra_pkg::A_XOFF, 16'h0013);
    wr(vra_pkg::CH_B, vra_pkg::A_IMSK, 16'h0421);
    wr(vra_pkg::CH_A, vra_pkg::A_PSET, 16'h030f);
    wr(vra_pkg::CH_A, vra_pkg::A_PCLR, 16'h0103);
    wr(vra_pkg::CH_B, vra_pkg::A_PSET, 16'h0081);
    chk({pd_o, po_o}, {20'haa955, 20'h2060c}, "pin outputs");
    rd(vra_pkg::CH_A, vra_pkg::A_PSET, 16'h0000);
    rd(vra_pkg::CH_A, vra_pkg::A_PCLR, 16'h0000);
    rd(vra_pkg::CH_B, vra_pkg::A_DIR, 16'h02aa);
    rd(vra_pkg::CH_B, vra_pkg::A_BRK, 16'hbeef);
    rd(vra_pkg::CH_B, vra_pkg::A_DLY, 16'h0007);
    rd(vra_pkg::CH_B, vra_pkg::A_XOFF, 16'h0013);
    rd(vra_pkg::CH_B, vra_pkg::A_IMSK, 16'h0421);
    // Reset in mid-run clears every register
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    #1;
    chk({pd_o, po_o, se_o, hs_o}, 64'h0, "mid-run reset pins");
    chk({pf_o, ci_o, bs_o, rv, rs}, 64'h0, "mid-run reset config");
    rd(vra_pkg::CH_B, vra_pkg::A_BRK, 16'h0000);
    $display("test pins done");
  endtask : t_pins

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_config;
    t_dedicated;
    t_errors;
    t_stall;
    t_pins;
    give_verdict;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    $display("[ERR] %0t timeout", $time);
    give_verdict;
  end
endmodule : tb_vra_top
